//--- hw/tcp_parser.sv
// Purpose: Transmit command buffer parser feeding the MAC transmit path
// Assumes: Host words arrive valid/ready; Avalon-MM register slave
// Notes:   Each buffer is command A, command B, then payload words
// Operation
// - Payload starts at third buffer word
// - Start offset from command A 20:16
// - Low offset bits choose first lane
// - Upper offset bits skip leading words
// - Bits 13 and 12 mark first/last
// - Offset, byte count and alignment give padding
// - Summed buffer counts checked against length
// - Length mismatch sets transmitter error
// - Tag carried into status word
// - Checksum request on bit 14, first, enabled
// - Bit 13 suppresses CRC append
// - Bit 12 disables pad, forces CRC
// - Bytes past count never forwarded
// - Host filler up to alignment discarded
// - Any start and end byte accepted
// - Differing command B sets error
// - Bits 25:24 select end alignment
// - Bit 31 raises buffer loaded flag
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module tcp_parser
(
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   // Host word stream
   input  wire logic [31:0]        in_data,
   input  wire logic               in_valid,
   output logic                    in_ready,
   // MAC transmit path
   output tcp_pkg::tcp_beat_type   out_beat,
   output tcp_pkg::tcp_opts_type   out_opts,
   output logic                    out_valid,
   input  wire logic               out_ready,
   // Status word for the finished packet
   output logic [31:0]             status_word,
   output logic                    status_valid,
   // Avalon-MM slave
   input  wire logic [7:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   output logic [31:0]             avs_readdata,
   output logic                    avs_waitrequest
);
   logic                   rs1_q, rst_sync_n;
   tcp_pkg::tcp_state_type state_q;
   logic [31:0]            cmd_a_q, cmd_b_q, first_b_q;
   logic [2:0]             lead_q;
   logic [11:0]            left_q;
   logic [4:0]             trail_q;
   logic [11:0]            sum_q;
   logic                   in_pkt_q, first_word_q, mismatch_q;
   logic                   csum_en_q, done_q, err_q;
   logic                   rd_ack_q;
   tcp_pkg::tcp_beat_type  beat_q;
   tcp_pkg::tcp_opts_type  opts_q;
   logic                   oval_q;
   logic [3:0]             be;
   logic [2:0]             used;
   logic [1:0]             lane_now;
   logic [4:0]             amask;
   logic [12:0]            span;
   logic [4:0]             pad_bytes;
   logic                   take, stall, buf_end, pkt_end, sum_bad;
   logic [11:0]            sum_new;

   // Reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs1_q      <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rs1_q      <= 1'b1;
         rst_sync_n <= rs1_q;
      end
   end

   // Output stage holds one beat; new beat only when it is free
   assign stall    = oval_q && !out_ready;
   assign in_ready = !stall;
   assign take     = in_valid && in_ready;
   assign lane_now = first_word_q ? cmd_a_q[tcp_pkg::CA_OFS_LO +: 2]
                                  : 2'h0;

   tcp_lane_mask u_mask
   (
      .first_lane (lane_now),
      .bytes_left (left_q),
      .be         (be),
      .used       (used)
   );

   // Alignment mask from command A
   always_comb
   begin
      case (cmd_a_q[tcp_pkg::CA_ALIGN_HI:tcp_pkg::CA_ALIGN_LO])
         tcp_pkg::ALIGN_16: amask = tcp_pkg::MASK_16;
         tcp_pkg::ALIGN_32: amask = tcp_pkg::MASK_32;
         default:           amask = tcp_pkg::MASK_4;
      endcase
   end

   // Bytes from data start to buffer end, offset and size included
   assign span = 13'(cmd_a_q[tcp_pkg::CA_OFS_HI:tcp_pkg::CA_OFS_LO])
               + 13'(cmd_a_q[tcp_pkg::LEN_HI:0]);
   // Filler bytes from the buffer end up to the end alignment; only whole words of them are dropped
   assign pad_bytes = 5'((~span[4:0] + 5'h01) & amask);

   assign buf_end = (12'(used) >= left_q);
   assign sum_new = sum_q + 12'(cmd_a_q[tcp_pkg::LEN_HI:0]);
   assign sum_bad = (sum_new[10:0] != cmd_b_q[tcp_pkg::LEN_HI:0]);
   assign pkt_end = cmd_a_q[tcp_pkg::CA_LAST_BIT];

   // Parser sequence
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         state_q      <= tcp_pkg::TCP_CMD_A;
         cmd_a_q      <= 32'h0;
         cmd_b_q      <= 32'h0;
         lead_q       <= 3'h0;
         left_q       <= 12'h0;
         trail_q      <= 5'h0;
         first_word_q <= 1'b0;
      end
      else if (take)
      begin
         case (state_q)
            tcp_pkg::TCP_CMD_A:
            begin
               cmd_a_q <= in_data;
               state_q <= tcp_pkg::TCP_CMD_B;
            end
            tcp_pkg::TCP_CMD_B:
            begin
               // Payload follows command A and B
               cmd_b_q      <= in_data;
               lead_q       <= cmd_a_q[tcp_pkg::CA_OFS_HI:
                                       tcp_pkg::CA_OFS_LO + 2];
               left_q       <= 12'(cmd_a_q[tcp_pkg::LEN_HI:0]);
               trail_q      <= pad_bytes;
               first_word_q <= 1'b1;
               if (cmd_a_q[tcp_pkg::CA_OFS_HI:tcp_pkg::CA_OFS_LO + 2] != 3'h0)
                  state_q <= tcp_pkg::TCP_LEAD;
               else if (cmd_a_q[tcp_pkg::LEN_HI:0] != 11'h0)
                  state_q <= tcp_pkg::TCP_PAY;
               else if (pad_bytes[4:2] != 3'h0)
                  state_q <= tcp_pkg::TCP_TRAIL;
               else
                  state_q <= tcp_pkg::TCP_CMD_A;
            end
            tcp_pkg::TCP_LEAD:
            begin
               // Whole leading words dropped
               lead_q <= lead_q - 3'h1;
               if (lead_q == 3'h1)
                  state_q <= (left_q != 12'h0) ? tcp_pkg::TCP_PAY
                           : (trail_q[4:2] != 3'h0) ? tcp_pkg::TCP_TRAIL
                           : tcp_pkg::TCP_CMD_A;
            end
            tcp_pkg::TCP_PAY:
            begin
               first_word_q <= 1'b0;
               left_q       <= buf_end ? 12'h0 : left_q - 12'(used);
               if (buf_end)
                  state_q <= (trail_q[4:2] != 3'h0) ? tcp_pkg::TCP_TRAIL
                                                    : tcp_pkg::TCP_CMD_A;
            end
            tcp_pkg::TCP_TRAIL:
            begin
               // Filler words dropped
               trail_q <= trail_q - 5'h04;
               if (trail_q[4:2] == 3'h1)
                  state_q <= tcp_pkg::TCP_CMD_A;
            end
            default: state_q <= tcp_pkg::TCP_CMD_A;
         endcase
      end
   end

   // Packet bookkeeping: running sum and command B comparison
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sum_q      <= 12'h0;
         in_pkt_q   <= 1'b0;
         first_b_q  <= 32'h0;
         mismatch_q <= 1'b0;
      end
      else if (take && state_q == tcp_pkg::TCP_CMD_B)
      begin
         // First segment restarts the packet
         if (cmd_a_q[tcp_pkg::CA_FIRST_BIT] || !in_pkt_q)
         begin
            first_b_q  <= in_data;
            mismatch_q <= 1'b0;
         end
         else if (in_data != first_b_q)
            mismatch_q <= 1'b1;
         sum_q    <= (cmd_a_q[tcp_pkg::CA_FIRST_BIT] || !in_pkt_q)
                   ? 12'(cmd_a_q[tcp_pkg::LEN_HI:0])
                   : 12'(sum_q + 12'(cmd_a_q[tcp_pkg::LEN_HI:0]));
         in_pkt_q <= !cmd_a_q[tcp_pkg::CA_LAST_BIT];
      end
   end

   // Forwarded beat and packet options
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         beat_q <= '0;
         opts_q <= '0;
         oval_q <= 1'b0;
      end
      else
      begin
         if (out_ready)
            oval_q <= 1'b0;
         if (take && state_q == tcp_pkg::TCP_PAY && be != 4'h0)
         begin
            beat_q.data  <= in_data;
            beat_q.be    <= be;
            beat_q.first <= first_word_q && cmd_a_q[tcp_pkg::CA_FIRST_BIT];
            beat_q.last  <= buf_end && pkt_end;
            opts_q.tag      <= cmd_b_q[tcp_pkg::CB_TAG_HI:tcp_pkg::CB_TAG_LO];
            opts_q.csum_req <= cmd_b_q[tcp_pkg::CB_CSUM_BIT] &&
                               cmd_a_q[tcp_pkg::CA_FIRST_BIT] &&
                               csum_en_q;
            opts_q.no_crc   <= cmd_b_q[tcp_pkg::CB_NOCRC_BIT];
            opts_q.no_pad   <= cmd_b_q[tcp_pkg::CB_NOPAD_BIT];
            opts_q.add_crc  <= cmd_b_q[tcp_pkg::CB_NOPAD_BIT] ||
                               !cmd_b_q[tcp_pkg::CB_NOCRC_BIT];
            oval_q <= 1'b1;
         end
      end
   end
   assign out_beat  = beat_q;
   assign out_opts  = opts_q;
   assign out_valid = oval_q;

   // Flags and status word; set wins over a software clear
   logic buf_done_ev, len_err_ev;
   assign buf_done_ev = take && cmd_a_q[tcp_pkg::CA_DONE_BIT] &&
      ((state_q == tcp_pkg::TCP_PAY && buf_end) ||
       (state_q == tcp_pkg::TCP_TRAIL && trail_q[4:2] == 3'h1));
   assign len_err_ev = take && state_q == tcp_pkg::TCP_CMD_B && pkt_end &&
      (((cmd_a_q[tcp_pkg::CA_FIRST_BIT] || !in_pkt_q)
         ? (cmd_a_q[tcp_pkg::LEN_HI:0] != in_data[tcp_pkg::LEN_HI:0])
         : sum_bad) ||
       (!cmd_a_q[tcp_pkg::CA_FIRST_BIT] && in_pkt_q &&
        (in_data != first_b_q || mismatch_q)));
   // One-cycle event: a level here would block the software clear
   logic mis_ev;
   assign mis_ev = take && state_q == tcp_pkg::TCP_CMD_B &&
      !cmd_a_q[tcp_pkg::CA_FIRST_BIT] && in_pkt_q && in_data != first_b_q;
   logic clr_w;
   assign clr_w = avs_write && !avs_waitrequest &&
                  avs_address == tcp_pkg::AV_STAT;

   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         done_q       <= 1'b0;
         err_q        <= 1'b0;
         status_word  <= 32'h0;
         status_valid <= 1'b0;
      end
      else
      begin
         status_valid <= 1'b0;
         if (buf_done_ev)
            done_q <= 1'b1;
         else if (clr_w && avs_writedata[tcp_pkg::ST_DONE])
            done_q <= 1'b0;
         if (len_err_ev || mis_ev)
            err_q <= 1'b1;
         else if (clr_w && avs_writedata[tcp_pkg::ST_ERR])
            err_q <= 1'b0;
         if (take && state_q == tcp_pkg::TCP_CMD_B && pkt_end)
         begin
            status_word  <= {in_data[tcp_pkg::CB_TAG_HI:tcp_pkg::CB_TAG_LO],
                             15'h0000, len_err_ev};
            status_valid <= 1'b1;
         end
      end
   end

   // Avalon slave: one wait cycle per access; writes land when it ends
   always_ff @(posedge sys_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         csum_en_q    <= 1'b0;
         rd_ack_q     <= 1'b0;
         avs_readdata <= 32'h0;
      end
      else
      begin
         rd_ack_q <= (avs_read || avs_write) && !rd_ack_q;
         if (avs_write && !avs_waitrequest &&
             avs_address == tcp_pkg::AV_CTRL)
            csum_en_q <= avs_writedata[0];
         case (avs_address)
            tcp_pkg::AV_CTRL: avs_readdata <= {31'h0, csum_en_q};
            tcp_pkg::AV_STAT: avs_readdata <= {30'h0, err_q, done_q};
            default:          avs_readdata <= 32'h0;
         endcase
      end
   end
   assign avs_waitrequest = (avs_read || avs_write) && !rd_ack_q;

   offset_lead_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) state_q == tcp_pkg::TCP_LEAD |-> !oval_q ||
      $stable(beat_q)) else $error("beat during lead skip");
   crc_force_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) oval_q && opts_q.no_pad |-> opts_q.add_crc)
      else $error("crc not forced");
   csum_gate_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) oval_q && opts_q.csum_req |-> csum_en_q)
      else $error("checksum without enable");
   status_tag_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) status_valid |->
      status_word[tcp_pkg::CB_TAG_HI:tcp_pkg::CB_TAG_LO] ==
      $past(in_data[tcp_pkg::CB_TAG_HI:tcp_pkg::CB_TAG_LO]))
      else $error("status tag differs from command B");
   beat_lanes_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) out_valid |-> out_beat.be != 4'h0)
      else $error("beat forwarded without bytes");
   len_err_a: assert property (@(posedge sys_clk) disable iff
      (!rst_sync_n) status_valid && status_word[0] |-> err_q)
      else $error("length error not flagged");
   cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
      state_q == tcp_pkg::TCP_TRAIL);
   cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
      $rose(err_q));
   cover property (@(posedge sys_clk) disable iff (!rst_sync_n)
      oval_q && out_beat.last);
endmodule : tcp_parser

//--- hw/tcp_pkg.sv
// Purpose: Shared constants and carriers for the transmit command parser
// Assumes: 32-bit host words, one clock
// Notes:   Field positions of both command words live here
package tcp_pkg;
   localparam int  CA_DONE_BIT   = 31;
   localparam int  CA_ALIGN_HI   = 25;
   localparam int  CA_ALIGN_LO   = 24;
   localparam int  CA_OFS_HI     = 20;
   localparam int  CA_OFS_LO     = 16;
   localparam int  CA_FIRST_BIT  = 13;
   localparam int  CA_LAST_BIT   = 12;
   localparam int  LEN_HI        = 10;
   localparam int  CB_TAG_HI     = 31;
   localparam int  CB_TAG_LO     = 16;
   localparam int  CB_CSUM_BIT   = 14;
   localparam int  CB_NOCRC_BIT  = 13;
   localparam int  CB_NOPAD_BIT  = 12;
   localparam logic [1:0] ALIGN_4  = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [4:0] MASK_16  = 5'h0f;
   localparam logic [4:0] MASK_32  = 5'h1f;
   localparam logic [4:0] MASK_4   = 5'h03;
   localparam logic [7:0] AV_CTRL  = 8'h00;
   localparam logic [7:0] AV_STAT  = 8'h04;
   localparam logic [1:0] ST_DONE  = 2'h0;
   localparam logic [1:0] ST_ERR   = 2'h1;

   typedef enum logic [2:0] {
      TCP_CMD_A, TCP_CMD_B, TCP_LEAD, TCP_PAY, TCP_TRAIL
   } tcp_state_type;

   typedef struct packed {
      logic [15:0] tag;
      logic        csum_req;
      logic        no_crc;
      logic        no_pad;
      logic        add_crc;
   } tcp_opts_type;

   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  be;
      logic        first;
      logic        last;
   } tcp_beat_type;
endpackage : tcp_pkg

//--- hw/tcp_lane_mask.sv
// Purpose: Byte-enable mask for one payload word
// Assumes: first_lane and bytes_left refer to the same word
// Notes:   Pure combinational
`timescale 1ns/1ps
module tcp_lane_mask
(
   // Word position
   input  wire logic [1:0]  first_lane,
   input  wire logic [11:0] bytes_left,
   // Result
   output logic      [3:0]  be,
   output logic      [2:0]  used
);
   logic [3:0] lane_ok;
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         // Lane must lie at or after the first lane and within the count
         assign lane_ok[g] = (2'(g) >= first_lane) &&
            (12'(g) - 12'(first_lane) < bytes_left);
      end
   endgenerate
   assign be   = lane_ok;
   assign used = 3'(lane_ok[0]) + 3'(lane_ok[1]) + 3'(lane_ok[2])
               + 3'(lane_ok[3]);
endmodule : tcp_lane_mask

//--- test/tcp_host_model.sv
// Purpose: Host model feeding command and data words to the parser
// Assumes: The bench queues whole buffers through push
// Notes:   Released data lines flip every cycle so stale words never match
`timescale 1ns/1ps
module tcp_host_model
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Word stream
   output logic      [31:0] in_data,
   output logic             in_valid,
   input  wire logic        in_ready
);
   logic [31:0] word_q[$];
   logic        slow = 1'b0;

   // Buffers are built legal: zero reserved bits, middle buffers of at
   // least four bytes, short packets, one command B per packet outside sc_cmdb
   task automatic push(input logic [31:0] w);
      word_q.push_back(w);
   endtask : push

   // Slow mode leaves an idle cycle after every accepted word
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_valid <= 1'b0;
         in_data  <= 32'h0;
      end
      else if (!in_valid || in_ready)
      begin
         if (word_q.size() > 0 && !(slow && in_valid))
         begin
            in_valid <= 1'b1;
            in_data  <= word_q.pop_front();
         end
         else
         begin
            in_valid <= 1'b0;
            in_data  <= ~in_data;
         end
      end
   end
endmodule : tcp_host_model

//--- test/tcp_parser_test.sv
// Purpose: Self-checking bench for the transmit command parser
// Assumes: Host model on the word stream, bench on the MAC side
// Notes:   Expected bytes come from the buffer images the bench builds
`timescale 1ns/1ps
module tcp_parser_test;
   logic                  sys_clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic [31:0]           in_data;
   logic                  in_valid;
   logic                  in_ready;
   tcp_pkg::tcp_beat_type out_beat;
   tcp_pkg::tcp_opts_type out_opts;
   tcp_pkg::tcp_opts_type opts_q;
   logic                  out_valid;
   logic                  out_ready = 1'b1;
   logic [31:0]           status_word;
   logic                  status_valid;
   logic [7:0]            avs_address = 8'h00;
   logic                  avs_read = 1'b0;
   logic                  avs_write = 1'b0;
   logic [31:0]           avs_writedata = 32'h0;
   logic [31:0]           avs_readdata;
   logic                  avs_waitrequest;
   logic [7:0]            exp_q[$];
   logic [7:0]            got_q[$];
   logic [31:0]           st_q[$];
   logic [15:0]           nf = 16'h0;
   logic [15:0]           nl = 16'h0;
   logic [3:0]            tick_q = 4'h0;
   logic                  stall_en = 1'b0;
   int                    num_errors = 0;
   int                    samples_checked = 0;

   always #50 sys_clk = ~sys_clk;

   tcp_host_model host_u (.sys_clk(sys_clk), .rst_n(rst_n),
      .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready));

   tcp_parser dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .in_data(in_data),
      .in_valid(in_valid), .in_ready(in_ready), .out_beat(out_beat),
      .out_opts(out_opts), .out_valid(out_valid), .out_ready(out_ready),
      .status_word(status_word), .status_valid(status_valid),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   // MAC side stalls one cycle in four when enabled
   always @(posedge sys_clk)
   begin
      tick_q    <= tick_q + 4'h1;
      out_ready <= !(stall_en && tick_q[1:0] == 2'h3);
      if (status_valid === 1'b1)
         st_q.push_back(status_word);
      if (out_valid === 1'b1 && out_ready === 1'b1)
      begin
         if (out_beat.first === 1'b1)
            opts_q = out_opts;
         nf = nf + 16'(out_beat.first === 1'b1);
         nl = nl + 16'(out_beat.last === 1'b1);
         for (int i = 0; i < 4; i++)
            if (out_beat.be[i] !== 1'b0)
               got_q.push_back(out_beat.data[8*i+:8]);
      end
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic results;
      if (num_errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic av_cyc(input logic wr, input logic [7:0] a,
                         input logic [31:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_read      <= !wr;
      avs_write     <= wr;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20)
      begin
         num_errors++;
         results();
      end
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : av_cyc

   function automatic logic [31:0] cmd_a(logic dn, logic [1:0] al,
      logic [4:0] ofs, logic fs, logic ls, logic [10:0] sz);
      return {dn, 5'h0, al, 3'h0, ofs, 2'h0, fs, ls, 1'b0, sz};
   endfunction : cmd_a

   function automatic logic [31:0] cmd_b(logic [15:0] tg, logic ck,
      logic nocrc, logic nopad, logic [10:0] len);
      return {tg, 1'b0, ck, nocrc, nopad, 1'b0, len};
   endfunction : cmd_b

   function automatic logic [31:0] pop_st();
      return (st_q.size() > 0) ? st_q.pop_front() : 32'hdeadbeef;
   endfunction : pop_st

   // Body image: junk before the offset and after the count, filler
   // whole words up to the end alignment counted from the data start
   task automatic send_buf(input logic [31:0] a, input logic [31:0] b,
                           input logic [7:0] base);
      int          ofs, sz, ab, nw;
      logic [31:0] w;
      ofs = a[20:16];
      sz  = a[10:0];
      ab  = (a[25:24] == tcp_pkg::ALIGN_32) ? 32 :
            (a[25:24] == tcp_pkg::ALIGN_16) ? 16 : 4;
      nw  = (ofs + sz + ab - 1) / ab * ab / 4;
      host_u.push(a);
      host_u.push(b);
      w = 32'h0;
      for (int i = 0; i < nw * 4; i++)
      begin
         w[8*(i%4)+:8] = (i >= ofs && i < ofs + sz) ? 8'(base + i) : 8'hee;
         if (i >= ofs && i < ofs + sz)
            exp_q.push_back(8'(base + i));
         if (i % 4 == 3)
            host_u.push(w);
      end
   endtask : send_buf

   task automatic drain(input int npk);
      int n;
      n = 0;
      while ((got_q.size() < exp_q.size() || host_u.word_q.size() > 0 ||
              in_valid) && n < 3000)
      begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 3000)
      begin
         num_errors++;
         results();
      end
      chk("byte count", exp_q.size(), got_q.size());
      foreach (exp_q[i])
         if (i < got_q.size())
            chk("byte", exp_q[i], got_q[i]);
      chk("segment flags", {16'(npk), 16'(npk)}, {nf, nl});
      exp_q = {};
      got_q = {};
      nf    = 16'h0;
      nl    = 16'h0;
   endtask : drain

   task automatic sc_regs;
      logic [31:0] r;
      av_cyc(1'b0, tcp_pkg::AV_CTRL, 32'h0, r);
      chk("ctrl reset", 32'h0, r);
      av_cyc(1'b1, 8'h08, 32'hffffffff, r);
      av_cyc(1'b0, 8'h08, 32'h0, r);
      chk("unmapped", 32'h0, r);
   endtask : sc_regs

   task automatic sc_single;
      logic [31:0] r;
      int          ofs_t[3] = '{7, 0, 31};
      int          sz_t[3] = '{10, 1, 33};
      for (int k = 0; k < 3; k++)
      begin
         send_buf(cmd_a(1'b1, 2'(k), 5'(ofs_t[k]), 1'b1, 1'b1, 11'(sz_t[k])),
                  cmd_b(16'(16'h1a0 + k), 1'b0, 1'b0, 1'b0, 11'(sz_t[k])),
                  8'(k * 40));
         drain(1);
         chk("status", {16'(16'h1a0 + k), 16'h0}, pop_st());
         av_cyc(1'b0, tcp_pkg::AV_STAT, 32'h0, r);
         chk("loaded flag", 32'h1, r);
         av_cyc(1'b1, tcp_pkg::AV_STAT, 32'h1, r);
         av_cyc(1'b0, tcp_pkg::AV_STAT, 32'h0, r);
         chk("loaded cleared", 32'h0, r);
      end
   endtask : sc_single

   // Three segments, slow host on the first pass only, stalling MAC; second pass is one short
   task automatic sc_multi;
      logic [31:0] r;
      logic [31:0] b;
      stall_en <= 1'b1;
      for (int k = 0; k < 2; k++)
      begin
         host_u.slow <= (k == 0);
         b = cmd_b(16'(16'h0b00 + k), 1'b0, 1'b0, 1'b0, 11'(111 - k));
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_16, 5'd7, 1'b1, 1'b0, 11'd79),
                  b, 8'h00);
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_16, 5'd0, 1'b0, 1'b0, 11'd15),
                  b, 8'h60);
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_16, 5'd10, 1'b0, 1'b1, 11'd17),
                  b, 8'h80);
         drain(1);
         chk("status", {16'(16'h0b00 + k), 15'h0, 1'(k)},
             pop_st());
         av_cyc(1'b0, tcp_pkg::AV_STAT, 32'h0, r);
         chk("length error", {30'h0, 1'(k), 1'b0}, r);
         av_cyc(1'b1, tcp_pkg::AV_STAT, 32'h3, r);
      end
      stall_en    <= 1'b0;
      host_u.slow <= 1'b0;
   endtask : sc_multi

   // Command B differs at the last segment, then only in the middle one
   task automatic sc_cmdb;
      logic [31:0] r;
      logic [31:0] b1;
      logic [31:0] b2;
      b1 = cmd_b(16'h0c01, 1'b0, 1'b0, 1'b0, 11'd16);
      b2 = cmd_b(16'h0c02, 1'b0, 1'b0, 1'b0, 11'd16);
      for (int k = 0; k < 2; k++)
      begin
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_4, 5'd0, 1'b1, 1'b0, 11'd4),
                  b1, 8'h20);
         if (k == 1)
            send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_4, 5'd0, 1'b0, 1'b0, 11'd4),
                     b2, 8'h24);
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_4, 5'd0, 1'b0, 1'b1,
                        11'(12 - 4 * k)), (k == 0) ? b2 : b1, 8'h28);
         drain(1);
         chk("mismatch status", {(k == 0) ? b2[31:16] : b1[31:16], 16'h1},
             pop_st());
         av_cyc(1'b0, tcp_pkg::AV_STAT, 32'h0, r);
         chk("command b mismatch", 32'h2, r);
         av_cyc(1'b1, tcp_pkg::AV_STAT, 32'h2, r);
         av_cyc(1'b0, tcp_pkg::AV_STAT, 32'h0, r);
         chk("error cleared", 32'h0, r);
      end
   endtask : sc_cmdb

   // Bit 3 of k enables the checksum engine, bits 2:0 are option bits
   task automatic sc_opts;
      logic [31:0] r;
      for (int k = 0; k < 16; k++)
      begin
         av_cyc(1'b1, tcp_pkg::AV_CTRL, {31'h0, k[3]}, r);
         send_buf(cmd_a(1'b0, tcp_pkg::ALIGN_4, 5'd0, 1'b1, 1'b1, 11'd4),
                  cmd_b(16'h0d00, k[2], k[1], k[0], 11'd4), 8'(k));
         drain(1);
         void'(pop_st());
         chk("options", {16'h0d00, k[2] & k[3], k[1], k[0], !k[1] | k[0]},
             opts_q);
      end
      av_cyc(1'b0, tcp_pkg::AV_CTRL, 32'h0, r);
      chk("ctrl readback", 32'h1, r);
   endtask : sc_opts

   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      sc_regs();
      sc_single();
      sc_multi();
      sc_cmdb();
      sc_opts();
      results();
   end
endmodule : tcp_parser_test
